// ===== core/rtc_out_pkg.sv
// Package with register map, field positions and timing constants of the RTC output block.
package rtc_out_pkg;

   // ----------------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------------
   localparam logic [3:0] ADDR_EXT = 4'hd;
   localparam logic [3:0] ADDR_FLAG = 4'he;
   localparam logic [3:0] ADDR_CTRL = 4'hf;

   // Flag register bit positions.
   localparam int UF_BIT = 5;
   localparam int TF_BIT = 4;
   localparam int AF_BIT = 3;
   // Control register bit positions.
   localparam int UIE_BIT = 5;
   localparam int TIE_BIT = 4;
   localparam int AIE_BIT = 3;
   localparam int STOP_BIT = 1;

   typedef struct packed {
      logic factoryTestBit;
      logic alarmWeekOrDaySelect;
      logic updateRateSelect;
      logic timerRun;
      logic freqSelectHi;
      logic freqSelectLo;
      logic timerSourceSelectHi;
      logic timerSourceSelectLo;
   } ext_reg_type;

   localparam ext_reg_type EXT_RESET = 8'h0c;

   // ----------------------------------------------------------------------
   // Clock output selections
   // ----------------------------------------------------------------------
   localparam logic [1:0] SEL_32K = 2'h0;
   localparam logic [1:0] SEL_1K = 2'h1;
   localparam logic [1:0] SEL_1HZ = 2'h2;
   localparam logic [1:0] SEL_GATED = 2'h3;

   // Taps of the 16-bit divider that counts 65536 Hz ticks.
   localparam int TAP_32K = 0;
   localparam int TAP_1K = 5;
   localparam int TAP_1HZ = 15;
   localparam logic [15:0] DIV_LAST = 16'hffff;

   // ----------------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------------
   localparam longint CLK_HZ = 40_000_000;
   localparam longint TICK_HZ = 65_536;
   // Phase step of the tick generator: TICK_HZ / CLK_HZ scaled by 2**32.
   localparam logic [31:0] NCO_STEP = 32'((TICK_HZ << 32) / CLK_HZ);
   // Longest low time of the update interrupt, in microseconds.
   localparam longint UPDATE_LOW_US = 7_800;
   localparam int UPDATE_LOW_CYCLES = int'((UPDATE_LOW_US * CLK_HZ) / 1_000_000);
   localparam int HOLD_W = 19;

endpackage : rtc_out_pkg

// ===== core/rtc_irq_and_clock_output.sv
// Interrupt pin gating and square-wave clock output of the real time clock.
`timescale 1ns/1ps

module rtc_irq_and_clock_output #(
   parameter int unsigned UPDATE_LOW_CYCLES = rtc_out_pkg::UPDATE_LOW_CYCLES
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Register port
   input wire logic regWrite,
   input wire logic [3:0] regAddr,
   input wire logic [7:0] regWData,
   output logic [7:0] regRData,
   // Event sources
   input wire logic timerEvent,
   input wire logic alarmEvent,
   input wire logic minuteEvent,
   // Clock output enable pin
   input wire logic clockOutEnablePin,
   // Open-drain interrupt pin
   output logic irqPinOut,
   output logic irqPinOeN,
   // Push-pull clock output pin
   output logic clockOutPin,
   output logic clockOutPinOeN
);

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   function automatic logic tapValue(input logic [1:0] sel, input logic [15:0] div,
                                     input logic halt);
      logic v;
      v = 1'b0;
      case (sel)
         rtc_out_pkg::SEL_32K, rtc_out_pkg::SEL_GATED: v = div[rtc_out_pkg::TAP_32K];
         rtc_out_pkg::SEL_1K: v = div[rtc_out_pkg::TAP_1K];
         rtc_out_pkg::SEL_1HZ: v = div[rtc_out_pkg::TAP_1HZ] & ~halt;
         default: v = 1'b0;
      endcase
      return v;
   endfunction : tapValue

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   logic [31:0] acc_q, acc_d;
   logic [15:0] div_q, div_d;
   rtc_out_pkg::ext_reg_type ext_q, ext_d;
   logic uf_q, uf_d, tf_q, tf_d, af_q, af_d;
   logic uie_q, uie_d, tie_q, tie_d, aie_q, aie_d, stop_q, stop_d;
   logic updLow_q, updLow_d;
   logic [rtc_out_pkg::HOLD_W-1:0] hold_q, hold_d;
   logic [1:0] curSel_q, curSel_d;
   logic [7:0] rdata_d;
   logic irqOeN_d, clkOut_d, clkOeN_d;
   logic tick, oneHzTick, updEvent, wrExt, wrFlag, wrCtrl;

   // ----------------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------------
   always_comb begin
      // Fractional divider: the 40 MHz clock cannot divide evenly to 65536 Hz,
      // so a phase accumulator makes ticks with a little jitter and a mean rate just under 65536 Hz, as NCO_STEP is truncated.
      {tick, acc_d} = {1'b0, acc_q} + {1'b0, rtc_out_pkg::NCO_STEP};
      div_d = tick ? div_q + 16'h0001 : div_q;
      oneHzTick = tick && (div_q == rtc_out_pkg::DIV_LAST);

      wrExt = regWrite && (regAddr == rtc_out_pkg::ADDR_EXT);
      wrFlag = regWrite && (regAddr == rtc_out_pkg::ADDR_FLAG);
      wrCtrl = regWrite && (regAddr == rtc_out_pkg::ADDR_CTRL);

      ext_d = wrExt ? rtc_out_pkg::ext_reg_type'(regWData) : ext_q;
      uie_d = wrCtrl ? regWData[rtc_out_pkg::UIE_BIT] : uie_q;
      tie_d = wrCtrl ? regWData[rtc_out_pkg::TIE_BIT] : tie_q;
      aie_d = wrCtrl ? regWData[rtc_out_pkg::AIE_BIT] : aie_q;
      stop_d = wrCtrl ? regWData[rtc_out_pkg::STOP_BIT] : stop_q;

      // A halted clock makes no update events.
      updEvent = ~stop_q & (ext_q.updateRateSelect ? minuteEvent : oneHzTick);

      // Flags: writing 0 clears, writing 1 keeps; a same-cycle event wins.
      uf_d = updEvent | (uf_q & ~(wrFlag & ~regWData[rtc_out_pkg::UF_BIT]));
      tf_d = timerEvent | (tf_q & ~(wrFlag & ~regWData[rtc_out_pkg::TF_BIT]));
      af_d = alarmEvent | (af_q & ~(wrFlag & ~regWData[rtc_out_pkg::AF_BIT]));

      updLow_d = updLow_q;
      hold_d = hold_q;
      // The enable as it will stand decides, so a clearing write in the event
      // cycle cannot leave the pin pulled low.
      if (updEvent && uie_d) begin
         updLow_d = 1'b1;
         hold_d = '0;
      end else if (updLow_q) begin
         hold_d = hold_q + 1'b1;
         if (!uie_d || !uf_d) begin
            updLow_d = 1'b0;
         end else if (hold_q == rtc_out_pkg::HOLD_W'(UPDATE_LOW_CYCLES - 1)) begin
            updLow_d = 1'b0;
         end
      end

      // Timer and alarm hold the pin while their flag and enable are both set.
      irqOeN_d = ~(updLow_d | (tf_d & tie_d) | (af_d & aie_d));

      // Selection changes only while both old and new taps are low, so no runt
      // pulse appears; the cost is a wait of up to half a slow period.
      curSel_d = curSel_q;
      if (tapValue(curSel_q, div_d, stop_d) == 1'b0 &&
          tapValue({ext_d.freqSelectHi, ext_d.freqSelectLo}, div_d, stop_d) == 1'b0) begin
         curSel_d = {ext_d.freqSelectHi, ext_d.freqSelectLo};
      end
      clkOut_d = tapValue(curSel_d, div_d, stop_d);
      clkOeN_d = (curSel_d == rtc_out_pkg::SEL_GATED) && !clockOutEnablePin;

      rdata_d = 8'h00;
      case (regAddr)
         rtc_out_pkg::ADDR_EXT: rdata_d = ext_q;
         rtc_out_pkg::ADDR_FLAG: begin
            rdata_d[rtc_out_pkg::UF_BIT] = uf_q;
            rdata_d[rtc_out_pkg::TF_BIT] = tf_q;
            rdata_d[rtc_out_pkg::AF_BIT] = af_q;
         end
         rtc_out_pkg::ADDR_CTRL: begin
            rdata_d[rtc_out_pkg::UIE_BIT] = uie_q;
            rdata_d[rtc_out_pkg::TIE_BIT] = tie_q;
            rdata_d[rtc_out_pkg::AIE_BIT] = aie_q;
            rdata_d[rtc_out_pkg::STOP_BIT] = stop_q;
         end
         default: rdata_d = 8'h00;
      endcase
   end

   // ----------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         acc_q <= '0;
         div_q <= '0;
         ext_q <= rtc_out_pkg::EXT_RESET;
         uf_q <= 1'b0;
         tf_q <= 1'b0;
         af_q <= 1'b0;
         uie_q <= 1'b0;
         tie_q <= 1'b0;
         aie_q <= 1'b0;
         stop_q <= 1'b0;
         updLow_q <= 1'b0;
         hold_q <= '0;
         curSel_q <= rtc_out_pkg::SEL_GATED;
         regRData <= 8'h00;
         irqPinOut <= 1'b0;
         irqPinOeN <= 1'b1;
         clockOutPin <= 1'b0;
         clockOutPinOeN <= 1'b1;
      end else begin
         acc_q <= acc_d;
         div_q <= div_d;
         ext_q <= ext_d;
         uf_q <= uf_d;
         tf_q <= tf_d;
         af_q <= af_d;
         uie_q <= uie_d;
         tie_q <= tie_d;
         aie_q <= aie_d;
         stop_q <= stop_d;
         updLow_q <= updLow_d;
         hold_q <= hold_d;
         curSel_q <= curSel_d;
         regRData <= rdata_d;
         irqPinOut <= 1'b0;
         irqPinOeN <= irqOeN_d;
         clockOutPin <= clkOut_d;
         clockOutPinOeN <= clkOeN_d;
      end
   end

endmodule : rtc_irq_and_clock_output

// ===== verif/rtc_out_sva.sv
// Port assertions for the interrupt pin and clock output block.
`timescale 1ns/1ps
module rtc_out_sva #(parameter int unsigned UPDATE_LOW_CYCLES = 20) (
   // Clock, reset and register port
   input wire logic clk,
   input wire logic rst,
   input wire logic regWrite,
   input wire logic [3:0] regAddr,
   input wire logic [7:0] regWData,
   input wire logic [7:0] regRData,
   // Events and pins
   input wire logic timerEvent,
   input wire logic alarmEvent,
   input wire logic minuteEvent,
   input wire logic clockOutEnablePin,
   input wire logic irqPinOut,
   input wire logic irqPinOeN,
   input wire logic clockOutPin,
   input wire logic clockOutPinOeN
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   logic [7:0] ctlQ, extQ;
   int lowQ, hiQ, selQ;
   wire wrC = regWrite && regAddr == rtc_out_pkg::ADDR_CTRL;
   wire wrF = regWrite && regAddr == rtc_out_pkg::ADDR_FLAG;
   wire wrE = regWrite && regAddr == rtc_out_pkg::ADDR_EXT;
   // Shadow registers; a select change waits for a common low, so age it.
   always_ff @(posedge clk) begin
      ctlQ <= rst ? 8'h00 : (wrC ? regWData : ctlQ);
      extQ <= rst ? 8'h0c : (wrE ? regWData : extQ);
      selQ <= (rst || (wrE && regWData[3:2] != extQ[3:2])) ? 0 : selQ + 1;
      lowQ <= (rst || irqPinOeN || minuteEvent) ? 0 : lowQ + 1;
      hiQ <= clockOutPin ? hiQ + 1 : 0;
   end
   AST_NO_IRQ: assert property (ctlQ[5:3] == 3'h0 |=> irqPinOeN)
      else $error("irq low with enables off");
   AST_UIE_OFF: assert property (wrC && regWData == 8'h00 |-> ##2 irqPinOeN)
      else $error("irq held after enable clear");
   AST_UPD_LOW: assert property (minuteEvent && ctlQ[5] && !ctlQ[1] && extQ[5] && !regWrite
      ##1 !regWrite |-> ##[0:1] !irqPinOeN) else $error("update irq missing");
   AST_LOW_MAX: assert property (ctlQ[4:3] == 2'h0 |-> lowQ <= UPDATE_LOW_CYCLES + 2)
      else $error("update irq too long");
   AST_FLAG_CLR: assert property (wrF && !regWData[5] && ctlQ[4:3] == 2'h0 && !minuteEvent
      ##1 !minuteEvent && !regWrite |=> irqPinOeN) else $error("irq held after flag clear");
   AST_SHARED: assert property ((timerEvent && ctlQ[4] || alarmEvent && ctlQ[3]) && !regWrite
      ##1 !regWrite |-> ##[0:1] !irqPinOeN) else $error("shared irq missing");
   AST_OE_OFF: assert property (extQ[3:2] == 2'h3 && selQ > 1300 && !clockOutEnablePin
      && !$past(clockOutEnablePin) |-> clockOutPinOeN) else $error("clock out not released");
   AST_F32K: assert property ($fell(clockOutPin) && extQ[3:2] == 2'h0 && selQ > 1300
      |-> hiQ inside {[608:613]}) else $error("bad 32768 Hz half period");
   AST_F1K: assert property ($fell(clockOutPin) && extQ[3:2] == 2'h1 && selQ > 45000
      |-> hiQ inside {[19525:19540]}) else $error("bad 1024 Hz half period");
   cover property (minuteEvent && ctlQ[5]);
   cover property ($fell(clockOutPin) && extQ[3:2] == 2'h1);
   cover property (clockOutPinOeN && selQ > 1300);
endmodule : rtc_out_sva

// ===== verif/rtc_host_model.sv
// Host side of the shared interrupt line.
`timescale 1ns/1ps
module rtc_host_model (
   // Device pin
   input wire logic irqPinOut,
   input wire logic irqPinOeN,
   // Line as the host sees it
   output logic irqLineN
);
   // The line carries a pull-up, so a released pin reads high.
   assign irqLineN = irqPinOeN ? 1'b1 : irqPinOut;
endmodule : rtc_host_model

// ===== verif/tb_top.sv
// Self-checking bench for the interrupt pin and clock output block.
`timescale 1ns/1ps
module tb_top;
   localparam int unsigned LOW = 20;
   localparam logic [3:0] EXT = rtc_out_pkg::ADDR_EXT;
   localparam logic [3:0] FLG = rtc_out_pkg::ADDR_FLAG;
   localparam logic [3:0] CTL = rtc_out_pkg::ADDR_CTRL;
   logic clk = 0, rst = 1, regWrite = 0, timerEvent = 0, alarmEvent = 0, minuteEvent = 0;
   logic clockOutEnablePin = 1, irqPinOut, irqPinOeN, clockOutPin, clockOutPinOeN;
   logic irqLineN, req = 0, reqD = 0;
   logic [3:0] regAddr = 4'h0;
   logic [7:0] regWData = 8'h00, regRData;
   logic [8:0] expQ[$], e, o;
   int badCount = 0, checkCount = 0;
   integer seed = 32'h3617_60fb;
   always #12.5 clk = ~clk;
   rtc_irq_and_clock_output #(.UPDATE_LOW_CYCLES(LOW)) dut (
      .clk(clk),
      .rst(rst),
      .regWrite(regWrite),
      .regAddr(regAddr),
      .regWData(regWData),
      .regRData(regRData),
      .timerEvent(timerEvent),
      .alarmEvent(alarmEvent),
      .minuteEvent(minuteEvent),
      .clockOutEnablePin(clockOutEnablePin),
      .irqPinOut(irqPinOut),
      .irqPinOeN(irqPinOeN),
      .clockOutPin(clockOutPin),
      .clockOutPinOeN(clockOutPinOeN)
   );
   rtc_host_model host (
      .irqPinOut(irqPinOut),
      .irqPinOeN(irqPinOeN),
      .irqLineN(irqLineN)
   );
   task automatic conclude();
      $display("checks %0d, mismatches %0d", checkCount, badCount);
      if (badCount == 0 && checkCount > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : conclude
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      regWrite <= 1'b1;
      regAddr <= a;
      regWData <= d;
      @(posedge clk);
      regWrite <= 1'b0;
   endtask : wr
   // Bit 8 set samples the pins as {enable, line}; clear reads a register.
   task automatic look(input logic [3:0] a, input logic [8:0] x);
      @(posedge clk);
      regAddr <= a;
      req <= 1'b1;
      expQ.push_back(x);
      @(posedge clk);
      req <= 1'b0;
   endtask : look
   task automatic pulse(input logic [2:0] v);
      @(posedge clk);
      {timerEvent, alarmEvent, minuteEvent} <= v;
      @(posedge clk);
      {timerEvent, alarmEvent, minuteEvent} <= 3'h0;
   endtask : pulse
   always @(posedge clk) reqD <= req;
   always @(negedge clk) if (reqD) begin
      e = expQ.pop_front();
      o = e[8] ? {7'h40, clockOutPinOeN, irqLineN} : {1'b0, regRData};
      checkCount++;
      if (o !== e) begin
         badCount++;
         $display("mismatch at %0t: got %h expected %h", $time, o, e);
      end
   end
   initial begin
      repeat (100000) @(posedge clk);
      badCount++;
      conclude();
   end
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      look(CTL, 9'h000);
      wr(4'h3, 8'($random(seed)));
      look(4'h3, 9'h000);
      look(EXT, 9'h00c);
      repeat (1400) @(posedge clk);
      clockOutEnablePin <= 1'b0;
      look(EXT, 9'h103);
      wr(EXT, 8'h00);
      repeat (1300) @(posedge clk);
      look(EXT, 9'h101);
      wr(EXT, 8'h0c);
      repeat (1300) @(posedge clk);
      look(EXT, 9'h103);
      clockOutEnablePin <= 1'b1;
      look(EXT, 9'h101);
      wr(EXT, 8'h2c);
      pulse(3'h1);
      look(EXT, 9'h101);
      look(FLG, 9'h020);
      wr(FLG, 8'hff);
      look(FLG, 9'h020);
      wr(CTL, 8'h20);
      look(CTL, 9'h020);
      pulse(3'h1);
      look(EXT, 9'h100);
      repeat (LOW) @(posedge clk);
      look(EXT, 9'h101);
      pulse(3'h1);
      wr(CTL, 8'h00);
      look(EXT, 9'h101);
      wr(CTL, 8'h20);
      wr(FLG, 8'h00);
      pulse(3'h1);
      wr(FLG, 8'h00);
      look(EXT, 9'h101);
      for (int i = 0; i < 2; i++) begin
         wr(CTL, i ? 8'h08 : 8'h10);
         pulse(i ? 3'h2 : 3'h4);
         look(EXT, 9'h100);
         look(FLG, i ? 9'h008 : 9'h010);
         wr(FLG, 8'h00);
         look(EXT, 9'h101);
      end
      wr(CTL, 8'h00);
      pulse(3'h7);
      look(EXT, 9'h101);
      look(FLG, 9'h038);
      wr(EXT, 8'h20);
      repeat (3000) @(posedge clk);
      wr(EXT, 8'h24);
      repeat (65000) @(posedge clk);
      wr(EXT, 8'h28);
      wr(CTL, 8'h02);
      clockOutEnablePin <= 1'($random(seed));
      look(EXT, 9'h101);
      repeat (4) @(posedge clk);
      conclude();
   end
endmodule : tb_top
bind rtc_irq_and_clock_output rtc_out_sva #(.UPDATE_LOW_CYCLES(UPDATE_LOW_CYCLES)) chk (
   .clk(clk),
   .rst(rst),
   .regWrite(regWrite),
   .regAddr(regAddr),
   .regWData(regWData),
   .regRData(regRData),
   .timerEvent(timerEvent),
   .alarmEvent(alarmEvent),
   .minuteEvent(minuteEvent),
   .clockOutEnablePin(clockOutEnablePin),
   .irqPinOut(irqPinOut),
   .irqPinOeN(irqPinOeN),
   .clockOutPin(clockOutPin),
   .clockOutPinOeN(clockOutPinOeN)
);
